/* verilog/hs_cmd_pkg.sv */
// constants for the host command register block
package hs_cmd_pkg;
    localparam logic [7:0]  cmd_reg_offset     = 8'h20;
    localparam logic [7:0]  sts_reg_offset     = 8'h24;
    localparam logic [7:0]  cap_reg_offset     = 8'h08;
    localparam logic [7:0]  hw_ctl_reg_offset  = 8'h40;
    localparam int          run_stop_pos       = 0;
    localparam int          ctl_reset_pos      = 1;
    localparam int          fls_lo_pos         = 2;
    localparam int          fls_hi_pos         = 3;
    localparam int          halted_pos         = 12;
    localparam int          cap_prog_list_pos  = 1;
    localparam logic [1:0]  fls_1024           = 2'h0;
    localparam logic [1:0]  fls_512            = 2'h1;
    localparam logic [1:0]  fls_256            = 2'h2;
    localparam logic [1:0]  fls_reset          = 2'h0;
    localparam logic [9:0]  idx_mask_1024      = 10'h3ff;
    localparam logic [9:0]  idx_mask_512       = 10'h1ff;
    localparam logic [9:0]  idx_mask_256       = 10'h0ff;
    localparam int          reset_time_ns      = 100;
    localparam int          clk_period_ns      = 5;
    localparam logic [7:0]  reset_cycles       = 8'((reset_time_ns + clk_period_ns - 1)
                                                    / clk_period_ns);
endpackage

/* verilog/hs_host_command_control.sv */
// command register control: frame list size, controller reset, run/stop and halt
// How it works
// [R01] size code 0/1/2 means 1024/512/256 entries
// [R02] size resets 0, writable only with capability
// [R03] size picks which frame index bits used
// [R04] reset bit clears pipelines, timers, state machines
// [R05] reset aborts running transaction at once
// [R06] reset drives no bus reset on ports
// [R07] reset leaves configuration space untouched
// [R08] reset restores operational and port registers
// [R09] reset returns port ownership to companions
// [R10] reset bit self-clears when sequence completes
// [R11] writing zero cannot cut reset short
// [R12] software re-initializes after reset
// [R13] software resets only a halted controller
// [R14] run bit one runs schedule continuously
// [R15] on stop, finish pipeline, then halt
// [R16] halted flag reports stopped state
// [R17] software checks halted before setting run
// [R18] halted resets one, zero while running
// [R19] reset bit reads one while in progress
//
// Strobed register access was chosen for this implementation.
module hs_host_command_control (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    output logic      [31:0] rdata,
    input  wire logic        prog_list_cap,
    input  wire logic        pipe_busy,
    input  wire logic        internal_error,
    output logic             run_enable,
    output logic             abort_txn,
    output logic             port_reset_drive,
    output logic             port_owner_companion,
    output logic             soft_reset_pulse,
    output logic      [9:0]  frame_index,
    output logic      [9:0]  list_index
);
    typedef enum logic [1:0] {st_halted, st_running, st_draining} run_state_t;

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic             run_stop_reg;
    logic       [1:0] fls_reg;
    logic             ctl_reset_reg;
    logic       [7:0] reset_cnt_reg;
    logic             halted_reg;
    logic             owner_reg;
    logic       [9:0] frame_cnt_reg;
    run_state_t       state_reg;
    logic             cmd_wr;
    logic             reset_done;
    logic             in_reset;

    function automatic logic [9:0] size_mask(input logic [1:0] sel);
        case (sel)
            hs_cmd_pkg::fls_512: size_mask = hs_cmd_pkg::idx_mask_512;
            hs_cmd_pkg::fls_256: size_mask = hs_cmd_pkg::idx_mask_256;
            default:             size_mask = hs_cmd_pkg::idx_mask_1024;
        endcase
    endfunction

    assign cmd_wr     = wr_stb && (addr == hs_cmd_pkg::cmd_reg_offset);
    assign in_reset   = ctl_reset_reg;
    assign reset_done = ctl_reset_reg && (reset_cnt_reg == 8'h01);

    // ----------------------------------------------------------------
    // controller reset sequence
    // ----------------------------------------------------------------
    // a zero written mid-sequence is ignored; only the counter ends it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctl_reset_reg <= 1'b0;
            reset_cnt_reg <= 8'h00;
        end else if (ctl_reset_reg) begin // R11
            reset_cnt_reg <= reset_cnt_reg - 8'h01;
            if (reset_done) begin
                ctl_reset_reg <= 1'b0; // R10
            end
        end else if (cmd_wr && wdata[hs_cmd_pkg::ctl_reset_pos]) begin
            ctl_reset_reg <= 1'b1; // R04
            reset_cnt_reg <= hs_cmd_pkg::reset_cycles;
        end
    end

    // one-cycle pulse to the rest of the core at the start of the sequence
    assign soft_reset_pulse     = ctl_reset_reg && (reset_cnt_reg == hs_cmd_pkg::reset_cycles);
    assign abort_txn            = ctl_reset_reg; // R05
    // port bus reset is only ever driven by the port logic, never from here
    assign port_reset_drive     = 1'b0; // R06
    assign port_owner_companion = owner_reg;

    // ----------------------------------------------------------------
    // command fields
    // ----------------------------------------------------------------
    // configuration space is outside this block and never sees the reset
    always_ff @(posedge clk) begin
        if (!rst_n || in_reset) begin // R08 R07
            run_stop_reg <= 1'b0;
        end else if (cmd_wr) begin
            run_stop_reg <= wdata[hs_cmd_pkg::run_stop_pos]; // R14
        end else if (internal_error) begin
            run_stop_reg <= 1'b0; // R18
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || in_reset) begin
            fls_reg <= hs_cmd_pkg::fls_reset; // R02
        end else if (cmd_wr && prog_list_cap) begin
            fls_reg <= wdata[hs_cmd_pkg::fls_hi_pos:hs_cmd_pkg::fls_lo_pos]; // R02
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || in_reset) begin
            owner_reg <= 1'b1; // R09
        end else if (wr_stb && addr == hs_cmd_pkg::hw_ctl_reg_offset) begin
            owner_reg <= wdata[0];
        end
    end

    // ----------------------------------------------------------------
    // run/stop state machine
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n || in_reset) begin
            state_reg  <= st_halted;
            halted_reg <= 1'b1; // R18
        end else begin
            case (state_reg)
                st_halted: begin
                    if (run_stop_reg) begin
                        state_reg  <= st_running;
                        halted_reg <= 1'b0; // R18
                    end
                end
                st_running: begin
                    if (!run_stop_reg) begin
                        state_reg <= st_draining; // R15
                    end
                end
                st_draining: begin
                    // halt only after the pipeline empties
                    if (!pipe_busy) begin // R15
                        state_reg  <= st_halted;
                        halted_reg <= 1'b1; // R16
                    end
                end
                default: state_reg <= st_halted;
            endcase
        end
    end

    assign run_enable = (state_reg == st_running);

    // ----------------------------------------------------------------
    // frame index counter and list index
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n || in_reset) begin
            frame_cnt_reg <= 10'h000;
        end else if (run_enable) begin
            frame_cnt_reg <= frame_cnt_reg + 10'h001;
        end
    end

    assign frame_index = frame_cnt_reg;
    assign list_index  = frame_cnt_reg & size_mask(fls_reg); // R03 R01

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata <= 32'h0000_0000;
        end else if (rd_stb) begin
            rdata <= 32'h0000_0000;
            case (addr)
                hs_cmd_pkg::cmd_reg_offset: begin
                    rdata[hs_cmd_pkg::run_stop_pos]  <= run_stop_reg;
                    rdata[hs_cmd_pkg::ctl_reset_pos] <= ctl_reset_reg; // R19
                    rdata[hs_cmd_pkg::fls_hi_pos:hs_cmd_pkg::fls_lo_pos] <= fls_reg;
                end
                hs_cmd_pkg::sts_reg_offset:
                    // the state machine starts one cycle late, so mask the flag once run is set
                    rdata[hs_cmd_pkg::halted_pos] <= halted_reg && !run_stop_reg; // R16 R18
                hs_cmd_pkg::cap_reg_offset:
                    rdata[hs_cmd_pkg::cap_prog_list_pos] <= prog_list_cap;
                hs_cmd_pkg::hw_ctl_reg_offset:
                    rdata[0] <= owner_reg;
                default: rdata <= 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    // cycles the reset bit has stood high; long runs are counted, not unrolled
    logic       [7:0] rst_len_reg;

    always_ff @(posedge clk) begin
        if (!rst_n || !ctl_reset_reg) begin
            rst_len_reg <= 8'h00;
        end else begin
            rst_len_reg <= rst_len_reg + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // controller reset checks
    // ----------------------------------------------------------------
    a_reset_selfclear: assert property (@(posedge clk) disable iff (!rst_n) // R10
        $fell(ctl_reset_reg) |->
        rst_len_reg == hs_cmd_pkg::reset_cycles)
        else $error("reset bit did not clear after sequence");

    a_reset_bounded: assert property (@(posedge clk) disable iff (!rst_n) // R10
        ctl_reset_reg |->
        rst_len_reg < hs_cmd_pkg::reset_cycles)
        else $error("reset sequence ran too long");

    a_reset_no_cut: assert property (@(posedge clk) disable iff (!rst_n) // R11
        ctl_reset_reg && !reset_done |=>
        ctl_reset_reg)
        else $error("reset sequence ended early");

    a_reset_starts: assert property (@(posedge clk) disable iff (!rst_n) // R04
        cmd_wr && wdata[hs_cmd_pkg::ctl_reset_pos] && !ctl_reset_reg |=>
        ctl_reset_reg && soft_reset_pulse)
        else $error("reset write did not start sequence");

    a_pulse_once: assert property (@(posedge clk) disable iff (!rst_n) // R04
        soft_reset_pulse |=>
        !soft_reset_pulse)
        else $error("reset pulse longer than one cycle");

    a_reset_clears: assert property (@(posedge clk) disable iff (!rst_n) // R08
        ctl_reset_reg |=> !run_stop_reg && halted_reg &&
        fls_reg == hs_cmd_pkg::fls_reset && frame_index == 10'h000)
        else $error("register state kept during reset");

    a_abort_reset: assert property (@(posedge clk) disable iff (!rst_n) // R05 R09
        ctl_reset_reg |=>
        !run_enable && port_owner_companion)
        else $error("activity or ownership kept during reset");

    a_no_bus_reset: assert property (@(posedge clk) disable iff (!rst_n) // R06
        ctl_reset_reg |->
        !port_reset_drive)
        else $error("bus reset driven during controller reset");

    a_reset_readback: assert property (@(posedge clk) disable iff (!rst_n) // R19
        rd_stb && addr == hs_cmd_pkg::cmd_reg_offset && ctl_reset_reg |=>
        rdata[hs_cmd_pkg::ctl_reset_pos])
        else $error("reset bit read zero while in progress");

    // ----------------------------------------------------------------
    // size field and list index checks
    // ----------------------------------------------------------------
    a_fls_locked: assert property (@(posedge clk) disable iff (!rst_n) // R02
        !prog_list_cap && !in_reset |=>
        $stable(fls_reg))
        else $error("size field changed without capability");

    a_fls_write: assert property (@(posedge clk) disable iff (!rst_n) // R02
        cmd_wr && prog_list_cap && !in_reset |=>
        fls_reg == $past(wdata[hs_cmd_pkg::fls_hi_pos:hs_cmd_pkg::fls_lo_pos]))
        else $error("size write with capability lost");

    a_list_mask: assert property (@(posedge clk) disable iff (!rst_n) // R03
        fls_reg == hs_cmd_pkg::fls_256 |->
        list_index[9:8] == 2'h0)
        else $error("list index exceeds 256 entries");

    a_list_512: assert property (@(posedge clk) disable iff (!rst_n) // R01
        fls_reg == hs_cmd_pkg::fls_512 |->
        list_index == {1'b0, frame_index[8:0]})
        else $error("list index wrong for 512 entries");

    a_list_1024: assert property (@(posedge clk) disable iff (!rst_n) // R01
        fls_reg == hs_cmd_pkg::fls_1024 |->
        list_index == frame_index)
        else $error("list index wrong for 1024 entries");

    // ----------------------------------------------------------------
    // run/stop and halt checks
    // ----------------------------------------------------------------
    a_halt_after_drain: assert property (@(posedge clk) disable iff (!rst_n || in_reset) // R15
        state_reg == st_draining && pipe_busy |=>
        !halted_reg)
        else $error("halted while pipeline busy");

    a_stop_drains: assert property (@(posedge clk) disable iff (!rst_n || in_reset) // R15
        state_reg == st_running && !run_stop_reg |=>
        state_reg == st_draining && !run_enable)
        else $error("stop did not enter draining");

    a_halt_on_idle: assert property (@(posedge clk) disable iff (!rst_n || in_reset) // R16
        state_reg == st_draining && !pipe_busy |=>
        halted_reg && !run_enable)
        else $error("did not halt once pipeline idle");

    a_halted_idle: assert property (@(posedge clk) disable iff (!rst_n) // R16
        state_reg == st_halted |->
        halted_reg)
        else $error("halted flag low while stopped");

    a_halted_running: assert property (@(posedge clk) disable iff (!rst_n) // R18
        state_reg == st_running |->
        !halted_reg)
        else $error("halted set while running");

    a_halted_read: assert property (@(posedge clk) disable iff (!rst_n) // R18
        rd_stb && addr == hs_cmd_pkg::sts_reg_offset && run_stop_reg |=>
        !rdata[hs_cmd_pkg::halted_pos])
        else $error("halted read one while run set");

    a_error_stops: assert property (@(posedge clk) disable iff (!rst_n) // R18
        internal_error && !cmd_wr |=>
        !run_stop_reg)
        else $error("internal error left run bit set");

    a_run_starts: assert property (@(posedge clk) disable iff (!rst_n || in_reset) // R14
        run_stop_reg && state_reg == st_halted |=>
        run_enable && !halted_reg)
        else $error("run bit did not start schedule");

    a_run_readback: assert property (@(posedge clk) disable iff (!rst_n) // R14
        rd_stb && addr == hs_cmd_pkg::cmd_reg_offset |=>
        rdata[hs_cmd_pkg::run_stop_pos] == $past(run_stop_reg))
        else $error("run bit read back wrong");

    a_frame_advance: assert property (@(posedge clk) disable iff (!rst_n) // R14
        run_enable && !in_reset |=>
        frame_index == $past(frame_index) + 10'h001)
        else $error("frame index did not advance while running");

    a_frame_hold: assert property (@(posedge clk) disable iff (!rst_n) // R14
        !run_enable && !in_reset |=>
        $stable(frame_index))
        else $error("frame index moved while stopped");

endmodule

/* verif/hs_host_command_control_bench.sv */
// self-checking bench for the host command register block
module hs_host_command_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk    = 1'b0;
    logic        rst_n  = 1'b0;
    logic [7:0]  addr   = 8'h00;
    logic [31:0] wdata  = 32'h0;
    logic        wr_stb = 1'b0;
    logic        rd_stb = 1'b0;
    logic        cap    = 1'b0;
    logic        busy   = 1'b0;
    logic        ierr   = 1'b0;
    logic [31:0] rdata, rv;
    logic        run_en, abort, prst, owner, srp;
    logic [9:0]  fidx, lidx, fv;
    int          n_fail = 0;
    int          compares = 0;
    int          cycles = 0;
    int          pulses = 0;
    integer      seed = 32'h966e;
    localparam logic [7:0] cmd = hs_cmd_pkg::cmd_reg_offset;
    localparam logic [7:0] sts = hs_cmd_pkg::sts_reg_offset;

    always #2.5 clk = ~clk;

    hs_host_command_control i_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .prog_list_cap(cap),
        .pipe_busy(busy), .internal_error(ierr), .run_enable(run_en), .abort_txn(abort),
        .port_reset_drive(prst), .port_owner_companion(owner), .soft_reset_pulse(srp),
        .frame_index(fidx), .list_index(lidx));

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask
    // read data is sampled 1ns after the clock edge, where it is settled
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 rv = rdata;
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------
    // hang guard and reset pulse counter
    // ------------------------------------------------
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (srp === 1'b1) pulses <= pulses + 1;
        if (cycles == 3000) begin
            n_fail++;
            end_sim();
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd(sts);
        chk("halted at reset", rv[12], 1);
        rd(cmd);
        chk("cmd at reset", rv[3:0], 0);
        wr(cmd, 32'h8);
        rd(cmd);
        chk("size read only", rv[3:2], 0);
        $display("reset values done");
        @(posedge clk) cap <= 1'b1;
        for (int c = 0; c < 3; c++) begin
            wr(cmd, 32'(c * 4 + 1));
            repeat (3) @(posedge clk);
            // let the frame count pass 768 so that the 512 and 256 masks clear real bits
            while (fidx[9:8] != 2'h3) @(posedge clk);
            rd(cmd);
            chk("size code", rv[3:2], c);
            chk("list index", lidx, fidx & 10'((1024 >> c) - 1));
            chk("running", run_en, 1);
            fv = fidx;
            @(posedge clk);
            #1 chk("frame count", fidx, 10'(fv + 10'h1));
        end
        rd(sts);
        chk("halted running", rv[12], 0);
        $display("size and run done");
        @(posedge clk) busy <= 1'b1;
        wr(cmd, 32'h8);
        repeat (5) @(posedge clk);
        rd(sts);
        chk("halted draining", rv[12], 0);
        @(posedge clk) busy <= 1'b0;
        repeat (3) @(posedge clk);
        rd(sts);
        chk("halted stopped", rv[12], 1);
        wr(cmd, 32'h9);
        @(posedge clk) ierr <= 1'b1;
        @(posedge clk) ierr <= 1'b0;
        repeat (4) @(posedge clk);
        rd(sts);
        chk("halted on error", rv[12], 1);
        chk("stopped on error", run_en, 0);
        $display("stop and halt done");
        wr(hs_cmd_pkg::hw_ctl_reg_offset, 32'h0);
        rd(hs_cmd_pkg::hw_ctl_reg_offset);
        chk("owner cleared", rv[0], 0);
        wr(cmd, 32'ha);
        rd(cmd);
        chk("reset bit busy", rv[1], 1);
        chk("size reset busy", rv[3:2], 0);
        chk("abort", abort, 1);
        wr(cmd, 32'h0);
        rd(cmd);
        chk("reset not cut", rv[1], 1);
        chk("no bus reset", prst, 0);
        repeat (25) @(posedge clk);
        rd(cmd);
        chk("reset bit clears", rv[3:0], 0);
        chk("frame reset", fidx, 0);
        chk("owner back", owner, 1);
        chk("abort ends", abort, 0);
        chk("pulse count", pulses, 1);
        rd(hs_cmd_pkg::cap_reg_offset);
        chk("capability", rv[1], 1);
        wr(cmd, 32'h1);
        repeat (2) @(posedge clk);
        #1 chk("runs again", run_en, 1);
        rd(sts);
        chk("halted after restart", rv[12], 0);
        $display("controller reset done");
        wr(8'h80 | 8'($random(seed) & 8'h7f), $random(seed));
        rd(8'h80 | 8'($random(seed) & 8'h7f));
        chk("unmapped", rv, 0);
        $display("unmapped done");
        end_sim();
    end
endmodule
